/* File: src/protection_logic_top.sv */
/*
  four-division trip logic with seal-in, two-out-of-four actuator voting,
  reset interlock and an AXI4-Lite slave for status, causes and test trips.
  assumes contact inputs are synchronous-slow and healthy-high (fail-safe).
*/
`timescale 1ns/100ps
`default_nettype none
module protection_logic_top #(
  parameter trip_pkg::timer_type RESET_DELAY_CYCLES = trip_pkg::timer_type'(trip_pkg::RESET_DELAY_CYCLES),
  parameter longint RESPONSE_MAX_CYCLES = trip_pkg::RESPONSE_MAX_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // axi4-lite write
  input wire logic [trip_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [trip_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // plant contacts, high when healthy
  input wire logic [3:0] stop_valve_open,
  input wire logic [3:0] oil_pressure_ok,
  input wire logic line_a_inner_position,
  input wire logic line_a_outer_position,
  input wire logic line_b_inner_position,
  input wire logic line_b_outer_position,
  input wire logic line_c_inner_position,
  input wire logic line_c_outer_position,
  input wire logic line_d_inner_position,
  input wire logic line_d_outer_position,
  input wire logic [3:0] level_switch_ok,
  input wire logic [3:0] level_unit_ok,
  input wire logic [3:0] drywell_pressure_ok,
  // operator switches
  input wire logic [3:0] manual_button_ok,
  input wire logic [3:0] mode_run_ok,
  input wire logic [3:0] reset_switch,
  // trip outputs
  output logic [3:0] division_trip,
  output logic [3:0] actuator_trip,
  output logic solenoid_power
);

  localparam int NSYNC = 36;

  logic [NSYNC-1:0] plant_sync;
  logic [3:0] reset_sync;
  logic [3:0] stop_t, oil_t, line_t, level_t, dry_t, man_t, mode_t;
  logic stop_vote, line_vote, dry_vote, coincident;
  logic [3:0] div_auto, div_manual, div_raw;
  logic [3:0] latch_reg, latch_next, raw_reg;
  logic [3:0] act_next;
  logic auto_seen_reg, auto_seen_next;
  logic reset_permit, delay_done, delay_restart;
  trip_pkg::timer_type delay_count;
  logic [3:0] test_reg;

  // open or de-energised contacts read low and therefore as trips
  input_sync #(.W(NSYNC), .RESET_VAL({NSYNC{1'b1}})) u_plant_sync (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .din({mode_run_ok, manual_button_ok, drywell_pressure_ok, level_unit_ok, level_switch_ok,
          line_d_outer_position, line_d_inner_position, line_c_outer_position, line_c_inner_position,
          line_b_outer_position, line_b_inner_position, line_a_outer_position, line_a_inner_position,
          oil_pressure_ok, stop_valve_open}),
    .dout(plant_sync)
  );

  input_sync #(.W(4), .RESET_VAL(4'h0)) u_reset_sync (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .din(reset_switch),
    .dout(reset_sync)
  );

  // channel trips, index = channel = division
  assign stop_t = ~plant_sync[3:0];
  assign oil_t = ~plant_sync[7:4];
  assign line_t[0] = ~plant_sync[8] | ~plant_sync[9];
  assign line_t[1] = ~plant_sync[10] | ~plant_sync[11];
  assign line_t[2] = ~plant_sync[12] | ~plant_sync[13];
  assign line_t[3] = ~plant_sync[14] | ~plant_sync[15];
  assign level_t = ~plant_sync[19:16] | ~plant_sync[23:20];
  assign dry_t = ~plant_sync[27:24];
  assign man_t = ~plant_sync[31:28];
  assign mode_t = ~plant_sync[35:32];

  // coincident variables vote across channels in every division
  assign stop_vote = trip_pkg::vote2(stop_t);
  assign line_vote = trip_pkg::vote2(line_t);
  assign dry_vote = trip_pkg::vote2(dry_t);
  assign coincident = stop_vote | line_vote | dry_vote;

  // non-coincident variables act on their own division only
  assign div_auto = {4{coincident}} | oil_t | level_t | mode_t;
  // buttons trip only their division; the actuator vote makes it two of four
  assign div_manual = man_t | test_reg;
  assign div_raw = div_auto | div_manual;

  assign delay_restart = |(div_raw & ~raw_reg);

  reset_delay_timer #(.DELAY_CYCLES(RESET_DELAY_CYCLES)) u_delay (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .restart(delay_restart),
    .done(delay_done),
    .count(delay_count)
  );

  // all four switches, causes gone (level included), hold-off over unless manual-only
  assign reset_permit = (&reset_sync) & ~(|div_raw) & (delay_done | ~auto_seen_reg);

  // a new trip in the reset cycle wins over the reset
  assign latch_next = div_raw | (latch_reg & ~(reset_sync & {4{reset_permit}}));

  assign auto_seen_next = (|div_auto) | (auto_seen_reg & (|latch_next));

  assign act_next = {4{trip_pkg::vote2(latch_next)}};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_reg <= 4'h0;
      raw_reg <= 4'h0;
      auto_seen_reg <= 1'b0;
      actuator_trip <= 4'h0;
      solenoid_power <= 1'b1;
    end else if (clk_en) begin
      latch_reg <= latch_next;
      raw_reg <= div_raw;
      auto_seen_reg <= auto_seen_next;
      actuator_trip <= act_next;
      solenoid_power <= ~trip_pkg::vote2(act_next);
    end
  end

  assign division_trip = latch_reg;

  // bus slave: address and data taken in either order, then one response
  trip_pkg::wr_state_type wr_state_reg, wr_state_next;
  logic aw_have_reg, w_have_reg;
  logic [trip_pkg::ADDR_W-1:0] awaddr_reg, araddr_word;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_take, w_take, wr_fire, ar_take, wr_hit, rd_hit;
  logic [31:0] status_word, cause_word, rd_word;

  assign s_axi_awready = ~aw_have_reg & (wr_state_reg == trip_pkg::WR_IDLE);
  assign s_axi_wready = ~w_have_reg & (wr_state_reg == trip_pkg::WR_IDLE);
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = (aw_have_reg | aw_take) & (w_have_reg | w_take) & (wr_state_reg == trip_pkg::WR_IDLE);
  logic [trip_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  assign wr_addr = aw_have_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_have_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_have_reg ? wstrb_reg : s_axi_wstrb;
  assign wr_hit = (wr_addr == trip_pkg::ADDR_TEST);
  assign wr_state_next = wr_fire ? trip_pkg::WR_RESP :
                         ((s_axi_bready & s_axi_bvalid) ? trip_pkg::WR_IDLE : wr_state_reg);
  assign s_axi_bvalid = (wr_state_reg == trip_pkg::WR_RESP);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_state_reg <= trip_pkg::WR_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bresp <= trip_pkg::RESP_OKAY;
      test_reg <= trip_pkg::TEST_RESET;
    end else if (clk_en) begin
      wr_state_reg <= wr_state_next;
      aw_have_reg <= (aw_have_reg | aw_take) & ~wr_fire;
      w_have_reg <= (w_have_reg | w_take) & ~wr_fire;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bresp <= wr_hit ? trip_pkg::RESP_OKAY : trip_pkg::RESP_SLVERR;
        if (wr_hit && wr_strb[0]) begin
          test_reg <= wr_data[3:0];
        end
      end
    end
  end

  // read side: one word in flight, answered the cycle after it is taken
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign araddr_word = s_axi_araddr;
  assign status_word = {20'h0, reset_permit, auto_seen_reg, delay_done, solenoid_power, actuator_trip, latch_reg};
  assign cause_word = {4'h0, mode_t, man_t, dry_t, level_t, line_t, oil_t, stop_t};
  assign rd_hit = (araddr_word == trip_pkg::ADDR_STATUS) | (araddr_word == trip_pkg::ADDR_CAUSE) |
                  (araddr_word == trip_pkg::ADDR_TEST) | (araddr_word == trip_pkg::ADDR_TIMER);
  assign rd_word = (araddr_word == trip_pkg::ADDR_STATUS) ? status_word :
                   (araddr_word == trip_pkg::ADDR_CAUSE) ? cause_word :
                   (araddr_word == trip_pkg::ADDR_TEST) ? {28'h0, test_reg} :
                   (araddr_word == trip_pkg::ADDR_TIMER) ? {3'h0, delay_count} : 32'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= trip_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? trip_pkg::RESP_OKAY : trip_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_stop_vote: assert property (clk_en && $countones(stop_t) >= 2 |=> &division_trip)
    else $error("stop valve vote did not trip all divisions");

  a_oil_channel: assert property (clk_en && |oil_t |=> (division_trip & $past(oil_t)) == $past(oil_t))
    else $error("oil pressure loss did not trip its division");

  a_line_pairs: assert property (clk_en && $countones(line_t) == 1 && !stop_vote && !dry_vote &&
    div_raw == 4'h0 |-> !line_vote)
    else $error("one steam line alone produced a vote");

  a_line_two: assert property (clk_en && $countones(line_t) >= 2 |=> &division_trip)
    else $error("two closed lines did not trip");

  a_level_either: assert property (clk_en && |level_t |=> (division_trip & $past(level_t)) == $past(level_t))
    else $error("high level did not trip its division");

  a_level_holds: assert property (|level_t |-> !reset_permit)
    else $error("reset permitted with high level present");

  a_drywell_one: assert property ($countones(dry_t) == 1 |-> !dry_vote)
    else $error("single drywell channel produced a vote");

  a_mode_trip: assert property (clk_en && |mode_t |=> (division_trip & $past(mode_t)) == $past(mode_t))
    else $error("shutdown mode did not trip");

  a_response_fast: assert property (clk_en && trip_pkg::vote2(div_raw) |=> !solenoid_power)
    else $error("solenoids not cut one cycle after two division trips");

  a_solenoid_vote: assert property (solenoid_power == !trip_pkg::vote2(actuator_trip))
    else $error("solenoid state disagrees with actuator vote");

  a_delay_holds: assert property (auto_seen_reg && !delay_done |-> !reset_permit)
    else $error("reset permitted during hold-off");

  a_manual_quick: assert property (!auto_seen_reg && &reset_sync && div_raw == 4'h0 |-> reset_permit)
    else $error("manual-only trip not resettable at once");

  a_all_switches: assert property (reset_permit |-> &reset_sync)
    else $error("reset permitted without all four switches");

  a_seal_in: assert property (clk_en && division_trip[0] && !reset_permit ##1 clk_en |-> division_trip[0])
    else $error("division trip dropped without permitted reset");

  a_line_route: assert property (!(&plant_sync[9:8]) |-> line_t[0])
    else $error("closed line a valve missed division one");

  a_line_quiet: assert property (&plant_sync[15:10] |-> line_t[3:1] == 3'h0)
    else $error("open steam lines reported as closed");

  a_manual_own: assert property (clk_en && |man_t |=> (division_trip & $past(man_t)) == $past(man_t))
    else $error("manual button did not trip its division");

  a_manual_vote: assert property (clk_en && $countones(man_t) >= 2 |=> !solenoid_power)
    else $error("two manual buttons did not cut the solenoids");

  a_reset_clear: assert property (clk_en && reset_permit |=> division_trip == 4'h0)
    else $error("permitted reset left a division tripped");

  a_delay_restart: assert property (clk_en && delay_restart |=> delay_count == '0)
    else $error("hold-off timer not restarted by a new trip");

  a_delay_hold: assert property (clk_en && delay_done && !delay_restart |=> delay_done)
    else $error("hold-off timer left its saturated state");

  // a de-energised contact must reach the logic as a trip after two enabled edges
  a_fail_safe: assert property (clk_en && !stop_valve_open[0] ##1 clk_en |=> stop_t[0])
    else $error("open stop valve contact not read as a trip");

  // the bench waits on these, so they are the bus timing promise
  a_write_answer: assert property (clk_en && wr_fire |=> s_axi_bvalid)
    else $error("write response did not follow the taken write");

  a_read_answer: assert property (clk_en && ar_take |=> s_axi_rvalid)
    else $error("read data did not follow the taken address");

  c_shutdown: cover property (clk_en && $fell(solenoid_power));
  c_auto_reset: cover property (auto_seen_reg && delay_done && reset_permit);
  c_manual_reset: cover property (!auto_seen_reg && |latch_reg && reset_permit);
  c_axi_test_write: cover property (wr_fire && wr_hit);
  c_level_blocks: cover property (|level_t && &reset_sync);

endmodule : protection_logic_top
`default_nettype wire

/* File: common/trip_pkg.sv */
/*
  shared constants for the four-division trip and voting logic: timing,
  register map of the bus slave, status and cause field positions.
  assumes a single 40 MHz logic clock.
*/
`default_nettype none
package trip_pkg;

  localparam int NUM_DIV = 4;
  localparam int CLK_HZ = 40_000_000;
  localparam int RESET_DELAY_S = 10;
  localparam longint RESET_DELAY_CYCLES = longint'(RESET_DELAY_S) * longint'(CLK_HZ);
  localparam int RESPONSE_MAX_MS = 30;
  localparam longint RESPONSE_MAX_CYCLES = longint'(RESPONSE_MAX_MS) * longint'(CLK_HZ) / 1000;
  localparam int TIMER_W = 29;
  typedef logic [TIMER_W-1:0] timer_type;

  // bus map
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CAUSE = 4'h4;
  localparam logic [3:0] ADDR_TEST = 4'h8;
  localparam logic [3:0] ADDR_TIMER = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] TEST_RESET = 4'h0;

  // status fields
  localparam int ST_LATCH = 0;
  localparam int ST_ACT = 4;
  localparam int ST_SOLENOID = 8;
  localparam int ST_DELAY_DONE = 9;
  localparam int ST_AUTO_SEEN = 10;
  localparam int ST_PERMIT = 11;

  // cause fields, four channel bits each
  localparam int CA_STOP = 0;
  localparam int CA_OIL = 4;
  localparam int CA_LINE = 8;
  localparam int CA_LEVEL = 12;
  localparam int CA_DRYWELL = 16;
  localparam int CA_MANUAL = 20;
  localparam int CA_MODE = 24;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_type;

  function automatic logic vote2(input logic [3:0] v);
    vote2 = (v[0] & (v[1] | v[2] | v[3])) | (v[1] & (v[2] | v[3])) | (v[2] & v[3]);
  endfunction : vote2

endpackage : trip_pkg
`default_nettype wire

/* File: src/input_sync.sv */
/*
  two-flop synchroniser for a vector of slow contact inputs.
  assumes inputs change slowly compared with the clock.
*/
`timescale 1ns/100ps
`default_nettype none
module input_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else if (clk_en) begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule : input_sync
`default_nettype wire

/* File: src/reset_delay_timer.sv */
/*
  saturating up-counter timing the hold-off before a reset is honoured.
  assumes restart is a single-cycle event from the trip logic.
*/
`timescale 1ns/100ps
`default_nettype none
module reset_delay_timer #(
  parameter trip_pkg::timer_type DELAY_CYCLES = trip_pkg::timer_type'(trip_pkg::RESET_DELAY_CYCLES)
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // control
  input wire logic restart,
  output logic done,
  output trip_pkg::timer_type count
);

  trip_pkg::timer_type count_reg;
  trip_pkg::timer_type count_next;

  assign done = (count_reg >= DELAY_CYCLES);
  // saturates so a long wait never wraps back into the hold-off
  assign count_next = restart ? '0 : (done ? count_reg : count_reg + 1'b1);
  assign count = count_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else if (clk_en) begin
      count_reg <= count_next;
    end
  end

endmodule : reset_delay_timer
`default_nettype wire

/* File: verif/plant_model.sv */
/*
  plant side of the trip logic: turns bench fault flags into healthy-high
  contacts and watches the pilot solenoids. assumes one bench clock.
*/
`timescale 1ns/100ps
`default_nettype none
module plant_model (
  // clock
  input wire logic clk,
  // bench commands, 1 = fault present or switch operated
  input wire logic [35:0] fault,
  input wire logic [3:0] reset_cmd,
  // contacts, high when healthy; reset switches high when operated
  output logic [3:0] stop_valve_open,
  output logic [3:0] oil_pressure_ok,
  output logic line_a_inner_position,
  output logic line_a_outer_position,
  output logic line_b_inner_position,
  output logic line_b_outer_position,
  output logic line_c_inner_position,
  output logic line_c_outer_position,
  output logic line_d_inner_position,
  output logic line_d_outer_position,
  output logic [3:0] level_switch_ok,
  output logic [3:0] level_unit_ok,
  output logic [3:0] drywell_pressure_ok,
  output logic [3:0] manual_button_ok,
  output logic [3:0] mode_run_ok,
  output logic [3:0] reset_switch,
  // pilot solenoids
  input wire logic solenoid_power,
  output logic rods_in
);
  // open contact reads as a trip, so a broken wire is safe
  assign stop_valve_open = ~fault[3:0];
  assign oil_pressure_ok = ~fault[7:4];
  assign {line_d_outer_position, line_d_inner_position, line_c_outer_position, line_c_inner_position,
          line_b_outer_position, line_b_inner_position, line_a_outer_position,
          line_a_inner_position} = ~fault[15:8];
  assign level_switch_ok = ~fault[19:16];
  assign level_unit_ok = ~fault[23:20];
  assign drywell_pressure_ok = ~fault[27:24];
  // arming collars taken as set
  assign manual_button_ok = ~fault[31:28];
  assign mode_run_ok = ~fault[35:32];
  assign reset_switch = reset_cmd;
  always_ff @(posedge clk) begin
    rods_in <= ~solenoid_power;
  end
endmodule : plant_model
`default_nettype wire

/* File: verif/protection_trip_voting_logic_tb.sv */
/*
  self-checking bench for the trip and voting logic: corner and random trips,
  seal-in, reset interlock and bus test trips. assumes the plant model beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module protection_trip_voting_logic_tb;
  // short hold-off so the run stays brief
  localparam int DLY = 100;
  localparam logic [35:0] CORNER [11] = '{36'h1, 36'h3, 36'h10, 36'h300, 36'h500, 36'h10000,
    36'h100000, 36'h1000000, 36'h3000000, 36'h30000000, 36'h100000000};
  logic clk, nrst, clk_en, solenoid_power, rods_in;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] stop_valve_open, oil_pressure_ok, level_switch_ok, level_unit_ok, drywell_pressure_ok;
  logic [3:0] manual_button_ok, mode_run_ok, reset_switch, division_trip, actuator_trip, rst_cmd;
  logic line_a_inner_position, line_a_outer_position, line_b_inner_position, line_b_outer_position;
  logic line_c_inner_position, line_c_outer_position, line_d_inner_position, line_d_outer_position;
  logic [35:0] fault;
  int bad_count;
  int n_checks;

  protection_logic_top #(.RESET_DELAY_CYCLES(trip_pkg::timer_type'(DLY))) uut (
    .clk, .nrst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .stop_valve_open, .oil_pressure_ok, .line_a_inner_position, .line_a_outer_position,
    .line_b_inner_position, .line_b_outer_position, .line_c_inner_position, .line_c_outer_position,
    .line_d_inner_position, .line_d_outer_position, .level_switch_ok, .level_unit_ok,
    .drywell_pressure_ok, .manual_button_ok, .mode_run_ok, .reset_switch, .division_trip,
    .actuator_trip, .solenoid_power);

  plant_model pm (
    .clk, .fault, .reset_cmd(rst_cmd), .stop_valve_open, .oil_pressure_ok, .line_a_inner_position,
    .line_a_outer_position, .line_b_inner_position, .line_b_outer_position, .line_c_inner_position,
    .line_c_outer_position, .line_d_inner_position, .line_d_outer_position, .level_switch_ok,
    .level_unit_ok, .drywell_pressure_ok, .manual_button_ok, .mode_run_ok, .reset_switch,
    .solenoid_power, .rods_in);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic v2(input logic [3:0] v);
    return $countones(v) >= 2;
  endfunction : v2

  // automatic causes: stop, line and drywell votes reach every division, the rest only their own
  function automatic logic [3:0] exp_auto(input logic [35:0] f);
    logic [3:0] lc;
    lc = {f[14] | f[15], f[12] | f[13], f[10] | f[11], f[8] | f[9]};
    return {4{v2(f[3:0]) | v2(lc) | v2(f[27:24])}} | f[7:4] | f[19:16] | f[23:20] | f[35:32];
  endfunction : exp_auto

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_out(input logic [3:0] d);
    chk({23'h0, division_trip, actuator_trip, solenoid_power}, {23'h0, d, {4{v2(d)}}, ~v2(d)});
  endtask : chk_out

  task automatic press(input logic [3:0] v);
    @(posedge clk);
    rst_cmd <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask : press

  // each valid drops at the rising edge that takes it; only the watchdog ends a wait
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd

  task automatic trial(input logic [35:0] f);
    logic [3:0] d;
    d = exp_auto(f) | f[31:28];
    @(posedge clk);
    fault <= f;
    repeat (3) @(posedge clk);
    #1;
    chk_out(d);
    @(posedge clk);
    fault <= '0;
    repeat (4) @(posedge clk);
    #1;
    chk_out(d);
    press(4'hf);
    // buttons alone reset at once, any automatic cause holds off
    if (exp_auto(f) == 4'h0) chk_out(4'h0);
    else chk_out(d);
    press(4'h0);
    repeat (DLY + 10) @(posedge clk);
    press(4'hf);
    chk_out(4'h0);
    press(4'h0);
  endtask : trial

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    $display("Error at %0t: timeout", $time);
    summarize();
  end

  initial begin
    logic [31:0] r;
    logic [31:0] d;
    logic [35:0] f;
    logic [1:0] resp;
    logic [3:0] t;
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fault, rst_cmd} = '0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'hf;
    void'($urandom(19));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_out(4'h0);
    for (int i = 0; i < 11; i++) trial(CORNER[i]);
    for (int i = 0; i < 24; i++) begin
      r = $urandom & $urandom & $urandom;
      t = 4'($urandom & $urandom & $urandom);
      f = (i % 3 == 0) ? {4'h0, r[31:28], 28'h0} : {t, r};
      trial(f);
    end
    // high level held through the hold-off keeps the latch
    @(posedge clk);
    fault <= 36'h10000;
    repeat (DLY + 10) @(posedge clk);
    press(4'hf);
    chk_out(4'h1);
    press(4'h0);
    @(posedge clk);
    fault <= '0;
    press(4'h7);
    chk_out(4'h1);
    press(4'hf);
    chk_out(4'h0);
    press(4'h0);
    for (int k = 0; k < 3; k++) begin
      t = (k == 0) ? 4'h3 : 4'($urandom);
      @(posedge clk);
      axi_wr(trip_pkg::ADDR_TEST, {28'h0, t}, resp);
      chk(32'(resp), 32'(trip_pkg::RESP_OKAY));
      repeat (4) @(posedge clk);
      #1;
      chk_out(t);
      chk({31'h0, rods_in}, {31'h0, v2(t)});
      @(posedge clk);
      axi_rd(trip_pkg::ADDR_STATUS, d, resp);
      chk({23'h0, d[8:0]}, {23'h0, ~v2(t), {4{v2(t)}}, t});
      axi_wr(trip_pkg::ADDR_TEST, 32'h0, resp);
      press(4'hf);
      chk_out(4'h0);
      press(4'h0);
    end
    @(posedge clk);
    // frozen logic ignores a trip until enabled, then answers in three edges
    clk_en <= 1'b0;
    fault <= 36'h3;
    repeat (6) @(posedge clk);
    #1;
    chk_out(4'h0);
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_out(4'hf);
    // reset in mid-run drops the latch and comes back healthy
    @(posedge clk);
    fault <= '0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_out(4'h0);
    @(posedge clk);
    axi_rd(4'h2, d, resp);
    chk(32'(resp), 32'(trip_pkg::RESP_SLVERR));
    chk(d, 32'h0);
    summarize();
  end
endmodule : protection_trip_voting_logic_tb
`default_nettype wire
